/* bench/cprm_mem_model.sv */
// Behavioural memory partner that stores the block's stack traffic
`timescale 1ns/100ps
module cprm_mem_model
  import cprm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire cprm_mem_s mem_i
);
  logic [7:0] store [0:65535];
  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  // No alignment check: odd word addresses must land as written
  always @(posedge sys_clk_i)
  begin
    if (mem_i.write)
    begin
      store[mem_i.addr] <= mem_i.byte0;
      if (mem_i.word)
      begin
        store[mem_i.addr_lo] <= mem_i.byte1;
      end
    end
  end
endmodule

/* bench/testbench.sv */
// Self-checking bench for the CPU programmer register model
`timescale 1ns/100ps
module testbench
  import cprm_pkg::*;
;
  typedef struct {string nm; int k; logic [19:0] e; int due; logic [15:0] ad;} cprm_note_s;
  logic sys_clk, reset_n, dj, stg_daa;
  cprm_load_s ld, stg_ld;
  cprm_flag_s fl, stg_fl;
  cprm_ea_s ea, stg_ea;
  cprm_stack_s st, stg_st;
  cprm_fetch_s fe, stg_fe;
  cprm_branch_s br, stg_br;
  cprm_ext_s ex, stg_ex;
  logic [7:0] acc_a_w, acc_b_w, ccr_w, a, b, cc;
  logic [15:0] acc_d_w, x_w, y_w, sp_w, pc_w, ea_w, x, y, sp, pc, eadr;
  logic [19:0] ext_w, mon_v;
  logic ea_valid_w, ea_rej_w, go_w, taken_w;
  cprm_mem_s mem_w;
  cprm_note_s notes[$];
  cprm_note_s mon_n;
  logic [31:0] rs;
  int cyc = 0;
  int fails = 0;
  int cmp_count = 0;
  cprm_regs u_cprm_regs (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .load_i(ld), .flag_i(fl), .daa_i(dj),
    .ea_i(ea), .stack_i(st), .fetch_i(fe), .branch_i(br), .ext_i(ex), .acc_a_o(acc_a_w), .acc_b_o(acc_b_w),
    .acc_d_o(acc_d_w), .idx_x_o(x_w), .idx_y_o(y_w), .stack_top_pointer_o(sp_w), .next_fetch_counter_o(pc_w),
    .condition_flags_register_o(ccr_w), .ext_acc_o(ext_w), .ea_addr_o(ea_w), .ea_valid_o(ea_valid_w),
    .ea_reject_o(ea_rej_w), .mem_o(mem_w), .instr_go_o(go_w), .branch_taken_o(taken_w));
  cprm_mem_model u_cprm_mem_model (.sys_clk_i(sys_clk), .mem_i(mem_w));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic bt(input logic [3:0] c, input logic [7:0] f);
    logic nv;
    nv = f[3] ^ f[1];
    case (c)
      4'h0: bt = 1'b1;
      4'h1: bt = 1'b0;
      4'h2: bt = !(f[0] | f[2]);
      4'h3: bt = f[0] | f[2];
      4'h4: bt = !f[0];
      4'h5: bt = f[0];
      4'h6: bt = !f[2];
      4'h7: bt = f[2];
      4'h8: bt = !f[1];
      4'h9: bt = f[1];
      4'hA: bt = !f[3];
      4'hB: bt = f[3];
      4'hC: bt = !nv;
      4'hD: bt = nv;
      4'hE: bt = !(f[2] | nv);
      default: bt = f[2] | nv;
    endcase
  endfunction
  function automatic logic [19:0] get(input int k, input logic [15:0] ad);
    case (k)
      0: get = 20'(acc_a_w);
      1: get = 20'(acc_b_w);
      2: get = 20'(acc_d_w);
      3: get = 20'(x_w);
      4: get = 20'(y_w);
      5: get = 20'(sp_w);
      6: get = 20'(pc_w);
      7: get = 20'(ccr_w);
      8: get = 20'(ea_w);
      9: get = 20'(ea_valid_w);
      10: get = 20'(ea_rej_w);
      11: get = 20'(go_w);
      12: get = 20'(taken_w);
      13: get = 20'(mem_w.write);
      14: get = 20'(mem_w.read);
      15: get = 20'(mem_w.addr);
      16: get = 20'(mem_w.addr_lo);
      17: get = 20'(mem_w.byte0);
      18: get = 20'(mem_w.byte1);
      19: get = ext_w;
      default: get = 20'(u_cprm_mem_model.store[ad]);
    endcase
  endfunction
  task automatic nt(input string nm, input int k, input logic [19:0] e, input int d = 1,
    input logic [15:0] ad = 16'h0000);
    notes.push_back('{nm, k, e, cyc + d, ad});
  endtask
  // Staged values land together so no input is written twice in one step
  task automatic go();
    @(posedge sys_clk);
    #1;
    ld = stg_ld;
    fl = stg_fl;
    dj = stg_daa;
    ea = stg_ea;
    st = stg_st;
    fe = stg_fe;
    br = stg_br;
    ex = stg_ex;
    {stg_ld, stg_fl, stg_daa, stg_ea, stg_st, stg_fe, stg_br, stg_ex} = '0;
  endtask
  task automatic snap(input int d);
    nt("acc_a", 0, 20'(a), d);
    nt("acc_b", 1, 20'(b), d);
    nt("acc_d", 2, 20'({a, b}), d);
    nt("idx_x", 3, 20'(x), d);
    nt("idx_y", 4, 20'(y), d);
    nt("sp", 5, 20'(sp), d);
    nt("pc", 6, 20'(pc), d);
    nt("ccr", 7, 20'(cc), d);
  endtask
  task automatic ldr(input cprm_dst_e d, input logic [15:0] v);
    stg_ld = '{d, 1'b0, 1'b0, v};
    go();
    case (d)
      DST_A: a = v[7:0];
      DST_B: b = v[7:0];
      DST_D: {a, b} = v;
      DST_X: x = v;
      DST_Y: y = v;
      DST_SP: sp = v;
      DST_PC: pc = v;
      default: cc = v[7:0];
    endcase
    snap(1);
  endtask
  task automatic push(input logic wd, input logic [15:0] w);
    logic [7:0] hb;
    logic [15:0] lo;
    hb = wd ? w[15:8] : w[7:0];
    stg_st = '{1'b1, 1'b0, wd, w};
    go();
    sp = sp - (wd ? 16'h0002 : 16'h0001);
    nt("sp", 5, 20'(sp));
    nt("mem_write", 13, 20'h00001);
    nt("mem_addr", 15, 20'(sp));
    nt("mem_byte0", 17, 20'(hb));
    nt("mem_data", 20, 20'(hb), 2, sp);
    if (wd)
    begin
      lo = sp + 16'h0001;
      nt("mem_addr_lo", 16, 20'(lo));
      nt("mem_byte1", 18, 20'(w[7:0]));
      nt("mem_data", 20, 20'(w[7:0]), 2, lo);
    end
  endtask
  task automatic daa_try(input logic [7:0] ai, input logic [7:0] ao, input logic cz);
    stg_ld = '{DST_A, 1'b0, 1'b0, {8'h00, ai}};
    stg_fl = '{5'h1F, 5'h00};
    go();
    a = ai;
    cc[5] = 1'b0;
    cc[3:0] = 4'h0;
    stg_daa = 1'b1;
    go();
    a = ao;
    cc[2] = cz;
    cc[0] = cz;
    snap(1);
  endtask
  task automatic run_ea(input int cnt);
    logic [31:0] r;
    cprm_base_e bs;
    cprm_ofs_e md;
    logic [15:0] bv, nb, off, ad, c;
    logic au, pre, dec;
    repeat (cnt)
    begin
      r = rnd();
      bs = cprm_base_e'(r[1:0]);
      md = cprm_ofs_e'(r[5:2] % 4'hA);
      c = r[31:16];
      au = (md >= OFS_PRE_DEC);
      pre = (md == OFS_PRE_DEC) || (md == OFS_PRE_INC);
      dec = (md == OFS_PRE_DEC) || (md == OFS_POST_DEC);
      bv = (bs == BASE_X) ? x : (bs == BASE_Y) ? y : (bs == BASE_SP) ? sp : pc;
      case (md)
        OFS_C5: off = {{11{c[4]}}, c[4:0]};
        OFS_C9: off = {{7{c[8]}}, c[8:0]};
        OFS_C16: off = c;
        OFS_ACC_A: off = {8'h00, a};
        OFS_ACC_B: off = {8'h00, b};
        OFS_ACC_D: off = {a, b};
        default: off = 16'h0000;
      endcase
      nb = !au ? bv : dec ? bv - 16'(r[18:16]) - 16'h0001 : bv + 16'(r[18:16]) + 16'h0001;
      stg_ea = '{1'b1, bs, md, c, r[18:16]};
      go();
      if (au && bs == BASE_PC)
      begin
        nt("ea_reject", 10, 20'h00001);
        nt("ea_valid", 9, 20'h00000);
        nt("ea_addr", 8, 20'(eadr));
        nt("pc", 6, 20'(pc));
      end
      else
      begin
        ad = pre ? nb : au ? bv : bv + off;
        eadr = ad;
        case (bs)
          BASE_X: x = nb;
          BASE_Y: y = nb;
          BASE_SP: sp = nb;
          default: pc = nb;
        endcase
        nt("ea_valid", 9, 20'h00001);
        nt("ea_addr", 8, 20'(ad));
        nt("ea_base", 3 + int'(bs), 20'(nb));
      end
    end
  endtask
  task automatic conclude();
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(negedge sys_clk)
  begin
    while (notes.size() > 0 && notes[0].due <= cyc)
    begin
      mon_n = notes.pop_front();
      mon_v = get(mon_n.k, mon_n.ad);
      cmp_count++;
      if (mon_v !== mon_n.e)
      begin
        $display("[ERR] %s expected %h seen %h", mon_n.nm, mon_n.e, mon_v);
        fails++;
      end
    end
  end
  initial
  begin
    #20000;
    fails++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [31:0] r;
    int i;
    int j;
    sys_clk = 1'b0;
    reset_n = 1'b0;
    rs = 32'h0000005E;
    {ld, fl, dj, ea, st, fe, br, ex} = '0;
    {stg_ld, stg_fl, stg_daa, stg_ea, stg_st, stg_fe, stg_br, stg_ex} = '0;
    {a, b, x, y, sp, pc, eadr} = '0;
    cc = 8'hD0;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    snap(0);
    ldr(DST_A, rnd());
    ldr(DST_B, rnd());
    ldr(DST_D, rnd());
    ldr(DST_X, rnd());
    ldr(DST_Y, rnd());
    ldr(DST_PC, 16'h0FFD);
    stg_ld = '{DST_X, 1'b1, 1'b1, 16'h1280};
    go();
    x = 16'hFF80;
    stg_ld = '{DST_Y, 1'b1, 1'b0, 16'h12F0};
    go();
    y = 16'h00F0;
    snap(1);
    repeat (24)
    begin
      r = rnd();
      stg_fe = '{1'b1, r[6:4], r[3:0]};
      go();
      nt("instr_go", 11, 20'(r[3:0] >= 4'h3));
      if (r[3:0] >= 4'h3)
        pc = pc + 16'(r[6:4]);
      nt("pc", 6, 20'(pc));
    end
    for (i = 0; i < 32; i++)
    begin
      r = rnd();
      stg_fl = '{r[9:5], r[4:0]};
      go();
      for (j = 0; j < 5; j++)
        if (r[5 + j])
          cc[(j == 4) ? 5 : j] = r[j];
      nt("ccr", 7, 20'(cc));
      stg_br = '{1'b1, cprm_cond_e'(i[3:0])};
      go();
      nt("taken", 12, 20'(bt(i[3:0], cc)));
    end
    ldr(DST_SP, 16'h1001);
    run_ea(60);
    stg_ea = '{1'b1, BASE_SP, OFS_POST_INC, 16'h0000, 3'h3};
    go();
    nt("ea_addr", 8, 20'(sp));
    eadr = sp;
    sp = sp + 16'h0004;
    nt("sp", 5, 20'(sp));
    ldr(DST_SP, 16'h2001);
    push(1'b0, rnd());
    push(1'b1, rnd());
    stg_st = '{1'b0, 1'b1, 1'b1, 16'h0000};
    go();
    nt("mem_read", 14, 20'h00001);
    nt("mem_write", 13, 20'h00000);
    nt("mem_addr", 15, 20'(sp));
    sp = sp + 16'h0002;
    nt("sp", 5, 20'(sp));
    ldr(DST_SP, 16'h0001);
    push(1'b1, 16'hABCD);
    daa_try(8'h0A, 8'h10, 1'b0);
    daa_try(8'hA0, 8'h00, 1'b1);
    stg_ex = '{1'b1, 1'b0, 20'hFFFFF};
    go();
    nt("ext_acc", 19, 20'hFFFFF);
    stg_ex = '{1'b0, 1'b1, 20'h00002};
    go();
    nt("ext_acc", 19, 20'h00001);
    stg_ex = '{1'b0, 1'b1, 20'h00003};
    go();
    nt("ext_acc", 19, 20'h00004);
    repeat (4) go();
    conclude();
  end
endmodule

/* rtl/cprm_add.sv */
// Parameterised wrap-around adder used for address and accumulator sums
`timescale 1ns/100ps
module cprm_add #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  output logic [W-1:0] sum_o
);

  // Wraps at 2**W; address space is circular
  assign sum_o = a_i + b_i;

endmodule

/* rtl/cprm_defines.svh */
// Named constants of the CPU programmer register model
`ifndef CPRM_DEFINES_SVH
`define CPRM_DEFINES_SVH

`define CPRM_CCR_RST 8'hD0
`define CPRM_BIT_S 7
`define CPRM_BIT_X 6
`define CPRM_BIT_H 5
`define CPRM_BIT_I 4
`define CPRM_BIT_N 3
`define CPRM_BIT_Z 2
`define CPRM_BIT_V 1
`define CPRM_BIT_C 0
`define CPRM_FLAG_H 4
`define CPRM_ZERO8 8'h00
`define CPRM_ZERO16 16'h0000
`define CPRM_ZERO20 20'h00000
`define CPRM_BYTE_STEP 16'h0001
`define CPRM_WORD_STEP 16'h0002
`define CPRM_QUEUE_MIN 4'h3
`define CPRM_BCD_NINE 4'h9
`define CPRM_DAA_FIX 4'h6
`define CPRM_NIB_ZERO 4'h0

`endif

/* rtl/cprm_pkg.sv */
// Types shared by the CPU programmer register model
package cprm_pkg;

  typedef enum logic [3:0] {
    DST_NONE = 4'h0,
    DST_A = 4'h1,
    DST_B = 4'h2,
    DST_D = 4'h3,
    DST_X = 4'h4,
    DST_Y = 4'h5,
    DST_SP = 4'h6,
    DST_PC = 4'h7,
    DST_CCR = 4'h8
  } cprm_dst_e;

  typedef enum logic [1:0] {
    BASE_X = 2'h0,
    BASE_Y = 2'h1,
    BASE_SP = 2'h2,
    BASE_PC = 2'h3
  } cprm_base_e;

  typedef enum logic [3:0] {
    OFS_C5 = 4'h0,
    OFS_C9 = 4'h1,
    OFS_C16 = 4'h2,
    OFS_ACC_A = 4'h3,
    OFS_ACC_B = 4'h4,
    OFS_ACC_D = 4'h5,
    OFS_PRE_DEC = 4'h6,
    OFS_PRE_INC = 4'h7,
    OFS_POST_DEC = 4'h8,
    OFS_POST_INC = 4'h9
  } cprm_ofs_e;

  typedef enum logic [3:0] {
    CND_ALWAYS = 4'h0,
    CND_NEVER = 4'h1,
    CND_HI = 4'h2,
    CND_LS = 4'h3,
    CND_CC = 4'h4,
    CND_CS = 4'h5,
    CND_NE = 4'h6,
    CND_EQ = 4'h7,
    CND_VC = 4'h8,
    CND_VS = 4'h9,
    CND_PL = 4'hA,
    CND_MI = 4'hB,
    CND_GE = 4'hC,
    CND_LT = 4'hD,
    CND_GT = 4'hE,
    CND_LE = 4'hF
  } cprm_cond_e;

  typedef struct packed {
    cprm_dst_e dst;
    logic byte_op;
    logic sign_ext;
    logic [15:0] data;
  } cprm_load_s;

  typedef struct packed {
    logic [4:0] mask;
    logic [4:0] value;
  } cprm_flag_s;

  typedef struct packed {
    logic req;
    cprm_base_e base;
    cprm_ofs_e mode;
    logic [15:0] constant;
    logic [2:0] step;
  } cprm_ea_s;

  typedef struct packed {
    logic push;
    logic pull;
    logic word;
    logic [15:0] data;
  } cprm_stack_s;

  typedef struct packed {
    logic start;
    logic [2:0] len;
    logic [3:0] queue_bytes;
  } cprm_fetch_s;

  typedef struct packed {
    logic eval;
    cprm_cond_e cond;
  } cprm_branch_s;

  typedef struct packed {
    logic load;
    logic add;
    logic [19:0] operand;
  } cprm_ext_s;

  typedef struct packed {
    logic write;
    logic read;
    logic word;
    logic [15:0] addr;
    logic [15:0] addr_lo;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } cprm_mem_s;

endpackage

/* rtl/cprm_regs.sv */
// CPU programmer register model: accumulators, index, stack, fetch counter, flags
`timescale 1ns/100ps
`include "cprm_defines.svh"
// ----------------------------------------------------------------------------
// How it works
// - Two separate 8-bit accumulators
// - Both accumulators act as one 16-bit word
// - Index base plus constant or accumulator
// - Stack pointer marks last used location
// - Stack pointer usable in all indexed forms
// - 16-bit counter holds next instruction address
// - Fetch counter refused for auto step forms
// - Flags: five status, two masks, stop disable
// - Half carry used for decimal adjust only
// - Branches test current N Z V C
// - Word high byte at lower address
// - Any byte address accessible singly
// - No alignment on words or instructions
// - Odd instruction lengths accepted
// - Start needs three queued bytes
// - Twenty-bit internal math register
// - Byte and word, signed and unsigned operands
// - Registers unreachable from the memory bus
// ----------------------------------------------------------------------------
module cprm_regs
  import cprm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire cprm_load_s load_i,
  input wire cprm_flag_s flag_i,
  input wire logic daa_i,
  input wire cprm_ea_s ea_i,
  input wire cprm_stack_s stack_i,
  input wire cprm_fetch_s fetch_i,
  input wire cprm_branch_s branch_i,
  input wire cprm_ext_s ext_i,
  output logic [7:0] acc_a_o,
  output logic [7:0] acc_b_o,
  output logic [15:0] acc_d_o,
  output logic [15:0] idx_x_o,
  output logic [15:0] idx_y_o,
  output logic [15:0] stack_top_pointer_o,
  output logic [15:0] next_fetch_counter_o,
  output logic [7:0] condition_flags_register_o,
  output logic [19:0] ext_acc_o,
  output logic [15:0] ea_addr_o,
  output logic ea_valid_o,
  output logic ea_reject_o,
  output cprm_mem_s mem_o,
  output logic instr_go_o,
  output logic branch_taken_o
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  // No bus port at all: software reaches these only through instructions
  logic [7:0] acc_a_reg, acc_a_next;
  logic [7:0] acc_b_reg, acc_b_next;
  logic [15:0] idx_x_reg, idx_x_next;
  logic [15:0] idx_y_reg, idx_y_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] ccr_reg, ccr_next;
  logic [19:0] ext_reg, ext_next;
  logic [15:0] ea_addr_reg, ea_addr_next;
  logic ea_valid_reg, ea_valid_next;
  logic ea_reject_reg, ea_reject_next;
  cprm_mem_s mem_reg, mem_next;
  logic instr_go_reg, instr_go_next;
  logic taken_reg, taken_next;

  // ----------------------------------------------------------------------------
  // Operand shaping
  // ----------------------------------------------------------------------------
  logic [15:0] ld_word;
  logic [15:0] ea_base, ea_ofs, ea_amt, ea_sum;
  logic ea_auto, ea_pre, ea_dec, ea_rej;
  logic [15:0] st_ofs, st_sum, pc_ofs, pc_sum;
  logic [19:0] ext_sum;
  logic cond_met;
  logic lo_fix, hi_fix;
  logic [7:0] daa_corr, daa_sum;

  always_comb
  begin
    // Byte operands widen by sign or zero extension
    ld_word = load_i.data;
    if (load_i.byte_op)
      ld_word = load_i.sign_ext ? {{8{load_i.data[7]}}, load_i.data[7:0]} : {`CPRM_ZERO8, load_i.data[7:0]};
  end

  always_comb
  begin
    case (ea_i.base)
      BASE_X: ea_base = idx_x_reg;
      BASE_Y: ea_base = idx_y_reg;
      BASE_SP: ea_base = sp_reg;
      BASE_PC: ea_base = pc_reg;
      default: ea_base = idx_x_reg;
    endcase
    ea_pre = (ea_i.mode == OFS_PRE_DEC) || (ea_i.mode == OFS_PRE_INC);
    ea_auto = ea_pre || (ea_i.mode == OFS_POST_DEC) || (ea_i.mode == OFS_POST_INC);
    ea_dec = (ea_i.mode == OFS_PRE_DEC) || (ea_i.mode == OFS_POST_DEC);
    ea_rej = ea_auto && (ea_i.base == BASE_PC);
    // Step field holds n-1, so 1 to 8
    ea_amt = {13'h0, ea_i.step} + `CPRM_BYTE_STEP;
    case (ea_i.mode)
      OFS_C5: ea_ofs = {{11{ea_i.constant[4]}}, ea_i.constant[4:0]};
      OFS_C9: ea_ofs = {{7{ea_i.constant[8]}}, ea_i.constant[8:0]};
      OFS_C16: ea_ofs = ea_i.constant;
      OFS_ACC_A: ea_ofs = {`CPRM_ZERO8, acc_a_reg};
      OFS_ACC_B: ea_ofs = {`CPRM_ZERO8, acc_b_reg};
      OFS_ACC_D: ea_ofs = {acc_a_reg, acc_b_reg};
      default: ea_ofs = ea_dec ? (~ea_amt + `CPRM_BYTE_STEP) : ea_amt;
    endcase
  end

  cprm_add #(.W(16)) u_ea_add (
    .a_i(ea_base),
    .b_i(ea_ofs),
    .sum_o(ea_sum)
  );

  // Push subtracts before the store, pull adds after the read
  always_comb
  begin
    st_ofs = stack_i.word ? `CPRM_WORD_STEP : `CPRM_BYTE_STEP;
    if (stack_i.push)
      st_ofs = ~st_ofs + `CPRM_BYTE_STEP;
    pc_ofs = {13'h0, fetch_i.len};
  end

  cprm_add #(.W(16)) u_st_add (
    .a_i(sp_reg),
    .b_i(st_ofs),
    .sum_o(st_sum)
  );
  cprm_add #(.W(16)) u_pc_add (
    .a_i(pc_reg),
    .b_i(pc_ofs),
    .sum_o(pc_sum)
  );
  cprm_add #(.W(20)) u_ext_add (
    .a_i(ext_reg),
    .b_i(ext_i.operand),
    .sum_o(ext_sum)
  );

  // Branch test on flags as the last flag-setting operation left them
  always_comb
  begin
    case (branch_i.cond)
      CND_ALWAYS: cond_met = 1'b1;
      CND_NEVER: cond_met = 1'b0;
      CND_HI: cond_met = !(ccr_reg[`CPRM_BIT_C] || ccr_reg[`CPRM_BIT_Z]);
      CND_LS: cond_met = ccr_reg[`CPRM_BIT_C] || ccr_reg[`CPRM_BIT_Z];
      CND_CC: cond_met = !ccr_reg[`CPRM_BIT_C];
      CND_CS: cond_met = ccr_reg[`CPRM_BIT_C];
      CND_NE: cond_met = !ccr_reg[`CPRM_BIT_Z];
      CND_EQ: cond_met = ccr_reg[`CPRM_BIT_Z];
      CND_VC: cond_met = !ccr_reg[`CPRM_BIT_V];
      CND_VS: cond_met = ccr_reg[`CPRM_BIT_V];
      CND_PL: cond_met = !ccr_reg[`CPRM_BIT_N];
      CND_MI: cond_met = ccr_reg[`CPRM_BIT_N];
      CND_GE: cond_met = !(ccr_reg[`CPRM_BIT_N] ^ ccr_reg[`CPRM_BIT_V]);
      CND_LT: cond_met = ccr_reg[`CPRM_BIT_N] ^ ccr_reg[`CPRM_BIT_V];
      CND_GT: cond_met = !(ccr_reg[`CPRM_BIT_Z] || (ccr_reg[`CPRM_BIT_N] ^ ccr_reg[`CPRM_BIT_V]));
      CND_LE: cond_met = ccr_reg[`CPRM_BIT_Z] || (ccr_reg[`CPRM_BIT_N] ^ ccr_reg[`CPRM_BIT_V]);
      default: cond_met = 1'b0;
    endcase
  end

  // Half carry has no other consumer than the decimal adjust
  always_comb
  begin
    lo_fix = ccr_reg[`CPRM_BIT_H] || (acc_a_reg[3:0] > `CPRM_BCD_NINE);
    hi_fix = ccr_reg[`CPRM_BIT_C] || (acc_a_reg[7:4] > `CPRM_BCD_NINE)
      || ((acc_a_reg[7:4] == `CPRM_BCD_NINE) && (acc_a_reg[3:0] > `CPRM_BCD_NINE));
    daa_corr = {hi_fix ? `CPRM_DAA_FIX : `CPRM_NIB_ZERO, lo_fix ? `CPRM_DAA_FIX : `CPRM_NIB_ZERO};
    daa_sum = acc_a_reg + daa_corr;
  end

  // ----------------------------------------------------------------------------
  // Next state; later sources win: fetch, load, flags, adjust, index, stack
  // ----------------------------------------------------------------------------
  always_comb
  begin
    acc_a_next = acc_a_reg;
    acc_b_next = acc_b_reg;
    idx_x_next = idx_x_reg;
    idx_y_next = idx_y_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    ccr_next = ccr_reg;
    ext_next = ext_reg;
    ea_addr_next = ea_addr_reg;
    mem_next = mem_reg;
    mem_next.write = 1'b0;
    mem_next.read = 1'b0;
    // Any length from one byte up advances the counter
    instr_go_next = fetch_i.start && (fetch_i.queue_bytes >= `CPRM_QUEUE_MIN);
    if (instr_go_next)
      pc_next = pc_sum;
    case (load_i.dst)
      DST_A: acc_a_next = load_i.data[7:0];
      DST_B: acc_b_next = load_i.data[7:0];
      DST_D: {acc_a_next, acc_b_next} = ld_word;
      DST_X: idx_x_next = ld_word;
      DST_Y: idx_y_next = ld_word;
      DST_SP: sp_next = ld_word;
      DST_PC: pc_next = ld_word;
      DST_CCR: ccr_next = load_i.data[7:0];
      default: ;
    endcase
    // Mask bits S, X, I change only by a whole flags load
    ccr_next[3:0] = (ccr_next[3:0] & ~flag_i.mask[3:0]) | (flag_i.value[3:0] & flag_i.mask[3:0]);
    if (flag_i.mask[`CPRM_FLAG_H])
      ccr_next[`CPRM_BIT_H] = flag_i.value[`CPRM_FLAG_H];
    if (daa_i)
    begin
      acc_a_next = daa_sum;
      ccr_next[`CPRM_BIT_C] = ccr_reg[`CPRM_BIT_C] || hi_fix;
      ccr_next[`CPRM_BIT_N] = daa_sum[7];
      ccr_next[`CPRM_BIT_Z] = (daa_sum == `CPRM_ZERO8);
    end
    if (ea_i.req && !ea_rej)
    begin
      ea_addr_next = (ea_auto && !ea_pre) ? ea_base : ea_sum;
      if (ea_auto)
        case (ea_i.base)
          BASE_X: idx_x_next = ea_sum;
          BASE_Y: idx_y_next = ea_sum;
          BASE_SP: sp_next = ea_sum;
          default: ;
        endcase
    end
    ea_valid_next = ea_i.req && !ea_rej;
    ea_reject_next = ea_i.req && ea_rej;
    if (stack_i.push)
    begin
      sp_next = st_sum;
      mem_next.write = 1'b1;
      mem_next.word = stack_i.word;
      mem_next.addr = st_sum;
      mem_next.byte0 = stack_i.word ? stack_i.data[15:8] : stack_i.data[7:0];
      mem_next.byte1 = stack_i.data[7:0];
    end
    else if (stack_i.pull)
    begin
      sp_next = st_sum;
      mem_next.read = 1'b1;
      mem_next.word = stack_i.word;
      mem_next.addr = sp_reg;
    end
    // Second byte of a word sits at the next address, odd or even
    mem_next.addr_lo = mem_next.addr + `CPRM_BYTE_STEP;
    taken_next = branch_i.eval && cond_met;
    if (ext_i.load)
      ext_next = ext_i.operand;
    else if (ext_i.add)
      ext_next = ext_sum;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      acc_a_reg <= `CPRM_ZERO8;
      acc_b_reg <= `CPRM_ZERO8;
      idx_x_reg <= `CPRM_ZERO16;
      idx_y_reg <= `CPRM_ZERO16;
      sp_reg <= `CPRM_ZERO16;
      pc_reg <= `CPRM_ZERO16;
      ccr_reg <= `CPRM_CCR_RST;
      ext_reg <= `CPRM_ZERO20;
      ea_addr_reg <= `CPRM_ZERO16;
      ea_valid_reg <= 1'b0;
      ea_reject_reg <= 1'b0;
      mem_reg <= '0;
      instr_go_reg <= 1'b0;
      taken_reg <= 1'b0;
    end
    else
    begin
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
      idx_x_reg <= idx_x_next;
      idx_y_reg <= idx_y_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      ccr_reg <= ccr_next;
      ext_reg <= ext_next;
      ea_addr_reg <= ea_addr_next;
      ea_valid_reg <= ea_valid_next;
      ea_reject_reg <= ea_reject_next;
      mem_reg <= mem_next;
      instr_go_reg <= instr_go_next;
      taken_reg <= taken_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign acc_a_o = acc_a_reg;
  assign acc_b_o = acc_b_reg;
  assign acc_d_o = {acc_a_reg, acc_b_reg};
  assign idx_x_o = idx_x_reg;
  assign idx_y_o = idx_y_reg;
  assign stack_top_pointer_o = sp_reg;
  assign next_fetch_counter_o = pc_reg;
  assign condition_flags_register_o = ccr_reg;
  assign ext_acc_o = ext_reg;
  assign ea_addr_o = ea_addr_reg;
  assign ea_valid_o = ea_valid_reg;
  assign ea_reject_o = ea_reject_reg;
  assign mem_o = mem_reg;
  assign instr_go_o = instr_go_reg;
  assign branch_taken_o = taken_reg;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_push_word;
    stack_i.push && stack_i.word && (load_i.dst != DST_SP) && !(ea_i.req && ea_i.base == BASE_SP);
  endsequence
  sequence s_pull_word;
    stack_i.pull && !stack_i.push && stack_i.word && (load_i.dst != DST_SP) && !(ea_i.req && ea_i.base == BASE_SP);
  endsequence
  AST_D_HALVES: assert property ((load_i.dst == DST_D) && !load_i.byte_op && !daa_i |=>
    (acc_a_o == $past(load_i.data[15:8])) && (acc_b_o == $past(load_i.data[7:0])))
    else $error("Double accumulator halves misplaced");
  AST_PUSH_PREDEC: assert property (s_push_word |=>
    (stack_top_pointer_o == $past(sp_reg) - `CPRM_WORD_STEP) && (mem_o.addr == stack_top_pointer_o) && mem_o.write)
    else $error("Push did not predecrement stack pointer");
  AST_PUSH_PULL: assert property (s_push_word ##1 s_pull_word |=>
    (stack_top_pointer_o == $past(sp_reg, 2)) && (mem_o.addr == $past(mem_o.addr)) && mem_o.read)
    else $error("Pull did not read last used stack location");
  AST_PC_AUTO_REFUSED: assert property (ea_i.req && ea_auto && (ea_i.base == BASE_PC) |=>
    ea_reject_o && !ea_valid_o)
    else $error("Auto step on fetch counter not refused");
  AST_SP_POST_INC: assert property (ea_i.req && (ea_i.base == BASE_SP) && (ea_i.mode == OFS_POST_INC)
    && !stack_i.push && !stack_i.pull && (load_i.dst != DST_SP) |=>
    ea_valid_o && (ea_addr_o == $past(sp_reg)) && (stack_top_pointer_o == $past(sp_reg) + $past(ea_amt)))
    else $error("Stack pointer post increment wrong");
  AST_QUEUE_GATE: assert property (fetch_i.start && (fetch_i.queue_bytes < `CPRM_QUEUE_MIN)
    && (load_i.dst != DST_PC) |=> !instr_go_o && $stable(next_fetch_counter_o))
    else $error("Instruction started with short queue");
  AST_ODD_ADVANCE: assert property (fetch_i.start && (fetch_i.queue_bytes >= `CPRM_QUEUE_MIN)
    && (load_i.dst != DST_PC) |=> instr_go_o && (next_fetch_counter_o == $past(pc_reg) + $past(pc_ofs)))
    else $error("Fetch counter advance wrong");
  AST_WORD_ORDER: assert property (stack_i.push && stack_i.word |=>
    (mem_o.byte0 == $past(stack_i.data[15:8])) && (mem_o.byte1 == $past(stack_i.data[7:0]))
    && (mem_o.addr_lo == mem_o.addr + `CPRM_BYTE_STEP))
    else $error("Word byte order wrong");
  AST_BRANCH_EQ: assert property (branch_i.eval && (branch_i.cond == CND_EQ) |=>
    branch_taken_o == $past(ccr_reg[`CPRM_BIT_Z]))
    else $error("Equal branch ignored zero flag");
  AST_EXT_ADD: assert property (ext_i.add && !ext_i.load ##1 ext_i.add && !ext_i.load |=>
    ext_acc_o == $past(ext_reg, 2) + $past(ext_i.operand, 2) + $past(ext_i.operand))
    else $error("Twenty-bit sum lost");
endmodule
